// >>> sbcl_bank.sv
// Purpose: state and timer of one memory bank
// Assumes: ok gates commands taken with cke high on both edges
// Notes: a command is judged against the state after this edge's timer expiry
`timescale 1ns/10ps
`include "sbcl_consts.svh"
module sbcl_bank (
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic ok,
	input wire logic hit,
	input wire logic ap,
	input sbcl_pkg::sbcl_cmd_t cmd,
	output sbcl_pkg::sbcl_bank_st_t st,
	output logic reject
);
	sbcl_pkg::sbcl_bank_s_t r, n;
	assign st = r.st;
	// timer expiry first, so a command on the edge where a delay is met is legal
	always_comb begin
		n = r;
		reject = 1'h0;
		if (r.tmr != 8'h00) begin
			n.tmr = r.tmr - 8'h01;
			if (r.tmr == 8'h01) begin
				case (r.st)
					sbcl_pkg::BK_ACTIVATING, sbcl_pkg::BK_READ, sbcl_pkg::BK_WRITE: n.st = sbcl_pkg::BK_ACTIVE;
					sbcl_pkg::BK_READ_AP, sbcl_pkg::BK_WRITE_AP: begin
						n.st = sbcl_pkg::BK_PRECHARGING;
						n.tmr = 8'(`SBCL_RP_CYC);
					end
					sbcl_pkg::BK_PRECHARGING: n.st = sbcl_pkg::BK_IDLE;
					default: n.st = r.st;
				endcase
			end
		end
		if (ok && hit) begin
			case (cmd)
				sbcl_pkg::CMD_ACT: begin
					if (n.st == sbcl_pkg::BK_IDLE) begin
						n.st = sbcl_pkg::BK_ACTIVATING;
						n.tmr = 8'(`SBCL_RCD_CYC);
					end else begin
						reject = 1'h1;
					end
				end
				sbcl_pkg::CMD_READ, sbcl_pkg::CMD_WRITE: begin
					if (n.st inside {sbcl_pkg::BK_ACTIVE, sbcl_pkg::BK_READ, sbcl_pkg::BK_WRITE}) begin
						if (cmd == sbcl_pkg::CMD_READ) begin
							// access period ends where the earliest explicit precharge could go
							n.st = ap ? sbcl_pkg::BK_READ_AP : sbcl_pkg::BK_READ;
							n.tmr = 8'(`SBCL_HALF_BL);
						end else if (ap) begin
							n.st = sbcl_pkg::BK_WRITE_AP;
							n.tmr = 8'(1 + `SBCL_HALF_BL + `SBCL_WR_CYC);
						end else begin
							n.st = sbcl_pkg::BK_WRITE;
							n.tmr = 8'(1 + `SBCL_HALF_BL);
						end
					end else begin
						reject = 1'h1;
					end
				end
				sbcl_pkg::CMD_PRE: begin
					if (n.st inside {sbcl_pkg::BK_ACTIVE, sbcl_pkg::BK_READ, sbcl_pkg::BK_WRITE}) begin
						n.st = sbcl_pkg::BK_PRECHARGING;
						n.tmr = 8'(`SBCL_RP_CYC);
					end else if (!(n.st inside {sbcl_pkg::BK_IDLE, sbcl_pkg::BK_PRECHARGING})) begin
						reject = 1'h1;
					end
				end
				sbcl_pkg::CMD_BST: begin
					if (n.st == sbcl_pkg::BK_READ) begin
						n.st = sbcl_pkg::BK_ACTIVE;
						n.tmr = 8'h00;
					end
				end
				default: n.st = n.st;
			endcase
		end
	end
	// bank state register
	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '{st: sbcl_pkg::BK_IDLE, tmr: 8'h00};
		end else if (clk_en) begin
			r <= n;
		end
	end
endmodule : sbcl_bank

// >>> sbcl_consts.svh
// Purpose: named timing, burst and width constants of the bank/cke legality block
// Assumes: 250 MHz clock, 4 ns period
// Notes: times in ns, cycle counts derived by rounding up
`ifndef SBCL_CONSTS_SVH
`define SBCL_CONSTS_SVH
`define SBCL_TCK_NS 4
`define SBCL_CYC_MIN(ns) (((ns) + `SBCL_TCK_NS - 1) / `SBCL_TCK_NS)
`define SBCL_T_RCD_NS 18
`define SBCL_T_RP_NS 18
`define SBCL_T_WR_NS 15
`define SBCL_T_WTR_NS 8
`define SBCL_T_MRD_NS 12
`define SBCL_T_RFC_NS 72
`define SBCL_T_XP_NS 25
`define SBCL_T_XSR_NS 120
`define SBCL_T_INIT_NS 200000
`define SBCL_RCD_CYC `SBCL_CYC_MIN(`SBCL_T_RCD_NS)
`define SBCL_RP_CYC `SBCL_CYC_MIN(`SBCL_T_RP_NS)
`define SBCL_WR_CYC `SBCL_CYC_MIN(`SBCL_T_WR_NS)
`define SBCL_WTR_CYC `SBCL_CYC_MIN(`SBCL_T_WTR_NS)
`define SBCL_MRD_CYC `SBCL_CYC_MIN(`SBCL_T_MRD_NS)
`define SBCL_RFC_CYC `SBCL_CYC_MIN(`SBCL_T_RFC_NS)
`define SBCL_XP_CYC `SBCL_CYC_MIN(`SBCL_T_XP_NS)
`define SBCL_XSR_CYC `SBCL_CYC_MIN(`SBCL_T_XSR_NS)
`define SBCL_INIT_CYC `SBCL_CYC_MIN(`SBCL_T_INIT_NS)
`define SBCL_SREF_TOGGLES 2
`define SBCL_BURST_LEN 4
`define SBCL_READ_LATENCY 3
`define SBCL_HALF_BL (`SBCL_BURST_LEN / 2)
`define SBCL_COL_QUIET (`SBCL_READ_LATENCY + `SBCL_HALF_BL + 1)
`define SBCL_IDLE_QUIET (1 + `SBCL_HALF_BL + `SBCL_WR_CYC + `SBCL_RP_CYC)
`define SBCL_TW 8
`define SBCL_NBANK 4
`define SBCL_LMR_NEEDED 2
`endif

// >>> sbcl_ctrl.sv
// Purpose: controller end; takes one user request at a time and issues it legally
// Assumes: user keeps same-bank delays (activate, precharge, refresh) itself
// Notes: one request held; ready returns the cycle after it issues or is dropped
`timescale 1ns/10ps
`include "sbcl_consts.svh"
module sbcl_ctrl #(
	parameter int INIT_WAIT_CYC = `SBCL_INIT_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	sbcl_if.ctrl bus,
	input wire logic req_valid,
	input sbcl_pkg::sbcl_op_t req_op,
	input wire logic [1:0] req_bank,
	input wire logic req_ap,
	output logic req_ready,
	output logic init_required,
	output logic asleep
);
	sbcl_pkg::sbcl_ctrl_s_t r, n;
	sbcl_pkg::sbcl_cmd_t c;
	logic fire;
	logic [`SBCL_TW-1:0] need;
	logic col_ok;
	logic idle_ok;

	assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = {r.cs_n, r.ras_n, r.cas_n, r.we_n};
	assign bus.cke = r.cke;
	assign bus.ap = r.ap;
	assign bus.ba = r.ba;
	assign req_ready = r.ready;
	assign init_required = r.init_req;
	assign asleep = (r.st == sbcl_pkg::HS_SLEEP);

	// spacing after the last column command; conservative, also for the same bank
	always_comb begin
		case (r.op)
			sbcl_pkg::OP_READ: need = r.last_wr ? 8'(1 + `SBCL_HALF_BL + `SBCL_WTR_CYC)
				: 8'(`SBCL_HALF_BL);
			sbcl_pkg::OP_WRITE: need = r.last_wr ? 8'(`SBCL_HALF_BL)
				: 8'(`SBCL_READ_LATENCY + `SBCL_HALF_BL);
			default: need = 8'h01;
		endcase
	end
	assign col_ok = (r.since_col >= need);
	assign idle_ok = (r.open == '0) && (r.since_any >= 8'(`SBCL_IDLE_QUIET));

	always_comb begin
		n = r;
		fire = 1'h0;
		c = sbcl_pkg::CMD_NOP;
		n.since_col = (r.since_col == 8'hff) ? r.since_col : r.since_col + 8'h01;
		n.since_any = (r.since_any == 8'hff) ? r.since_any : r.since_any + 8'h01;
		case (r.st)
			sbcl_pkg::HS_RUN: begin
				if (r.hold) begin
					case (r.op)
						sbcl_pkg::OP_ACT, sbcl_pkg::OP_PRE: begin
							fire = col_ok;
							c = (r.op == sbcl_pkg::OP_ACT) ? sbcl_pkg::CMD_ACT : sbcl_pkg::CMD_PRE;
						end
						sbcl_pkg::OP_READ, sbcl_pkg::OP_WRITE: begin
							fire = col_ok;
							c = (r.op == sbcl_pkg::OP_READ) ? sbcl_pkg::CMD_READ : sbcl_pkg::CMD_WRITE;
						end
						sbcl_pkg::OP_BST: begin
							fire = 1'h1;
							c = sbcl_pkg::CMD_BST;
						end
						sbcl_pkg::OP_AREF, sbcl_pkg::OP_LMR: begin
							fire = idle_ok;
							c = (r.op == sbcl_pkg::OP_AREF) ? sbcl_pkg::CMD_AREF : sbcl_pkg::CMD_LMR;
						end
						sbcl_pkg::OP_PD: begin
							fire = (r.since_col >= 8'(`SBCL_COL_QUIET));
							n.cke = !fire;
							// a plain power-down wakes without initialization
							n.deep = 1'h0;
						end
						sbcl_pkg::OP_SREF, sbcl_pkg::OP_DEEP: begin
							fire = idle_ok;
							n.cke = !fire;
							n.deep = (r.op == sbcl_pkg::OP_DEEP);
							c = n.deep ? sbcl_pkg::CMD_BST : sbcl_pkg::CMD_AREF;
						end
						default: n.hold = 1'h0;
					endcase
					if (fire && !n.cke) begin
						n.st = sbcl_pkg::HS_SLEEP;
					end
				end
			end
			sbcl_pkg::HS_SLEEP: begin
				// only a wake request is honoured; others are dropped
				if (r.hold) begin
					n.hold = 1'h0;
					if (r.op == sbcl_pkg::OP_WAKE) begin
						n.cke = 1'h1;
						n.exit_cnt = 8'(`SBCL_XSR_CYC > `SBCL_SREF_TOGGLES ? `SBCL_XSR_CYC
							: `SBCL_SREF_TOGGLES);
						n.st = r.deep ? sbcl_pkg::HS_INIT : sbcl_pkg::HS_EXIT;
						n.wait_cnt = 16'(INIT_WAIT_CYC);
						n.init_req = r.deep;
						n.lmr_cnt = 2'h0;
					end
				end
			end
			sbcl_pkg::HS_EXIT: begin
				// pins stay nop while the exit time runs
				n.exit_cnt = r.exit_cnt - 8'h01;
				if (r.exit_cnt == 8'h01) begin
					n.st = sbcl_pkg::HS_RUN;
				end
			end
			sbcl_pkg::HS_INIT: begin
				// after the deepest sleep: wait, then only precharge, refresh and mode loads
				if (r.wait_cnt != 16'h0000) begin
					n.wait_cnt = r.wait_cnt - 16'h0001;
				end else if (r.hold) begin
					case (r.op)
						sbcl_pkg::OP_PRE: c = sbcl_pkg::CMD_PRE;
						sbcl_pkg::OP_AREF: c = sbcl_pkg::CMD_AREF;
						sbcl_pkg::OP_LMR: c = sbcl_pkg::CMD_LMR;
						default: n.hold = 1'h0;
					endcase
					fire = n.hold;
					if (fire && c == sbcl_pkg::CMD_LMR) begin
						n.lmr_cnt = r.lmr_cnt + 2'h1;
						if (r.lmr_cnt == 2'(`SBCL_LMR_NEEDED - 1)) begin
							n.st = sbcl_pkg::HS_RUN;
							n.init_req = 1'h0;
						end
					end
				end
			end
			default: n.st = sbcl_pkg::HS_RUN;
		endcase
		// pins: one-cycle command when fired, nop otherwise
		{n.ras_n, n.cas_n, n.we_n} = sbcl_pkg::sbcl_encode(fire ? c : sbcl_pkg::CMD_NOP);
		n.cs_n = 1'h0;
		n.ap = fire && r.hap;
		if (fire) begin
			n.hold = 1'h0;
			n.ba = r.bank;
			n.since_any = 8'h00;
			if (c == sbcl_pkg::CMD_READ || c == sbcl_pkg::CMD_WRITE) begin
				n.since_col = 8'h00;
				n.last_wr = (c == sbcl_pkg::CMD_WRITE);
				n.open[r.bank] = !r.hap;
			end else if (c == sbcl_pkg::CMD_ACT) begin
				n.open[r.bank] = 1'h1;
			end else if (c == sbcl_pkg::CMD_PRE) begin
				n.open = r.hap ? '0 : (r.open & ~(4'h1 << r.bank));
			end
		end
		// take a new request only while nothing is held
		if (req_valid && r.ready) begin
			n.hold = 1'h1;
			n.op = req_op;
			n.bank = req_bank;
			n.hap = req_ap;
		end
		n.ready = !n.hold;
	end

	// state register; pins deselect with enable high during reset
	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '{cs_n: 1'h1, ras_n: 1'h1, cas_n: 1'h1, we_n: 1'h1, cke: 1'h1, ready: 1'h1,
				op: sbcl_pkg::OP_ACT, st: sbcl_pkg::HS_RUN, since_col: 8'hff, since_any: 8'hff,
				default: '0};
		end else if (clk_en) begin
			r <= n;
		end
	end
endmodule : sbcl_ctrl

// >>> sbcl_dram.sv
// Purpose: memory end; tracks four banks and power state, flags illegal commands
// Assumes: command bus comes from logic on the same clk, so it is read without sync
// Notes: illegal_cmd is a one-cycle report; an illegal command changes no bank state, except a precharge with ap set, which still closes the banks that accept it
`timescale 1ns/10ps
`include "sbcl_consts.svh"
// What this block does
// - chip select high means deselect, continue
// - all strobes high decodes as no-operation
// - decode active, read, write, precharge encodings
// - idle bank n leaves bank m free
// - busy bank n still allows other-bank commands
// - write waits until any read burst ends
// - read interrupting write needs data masking
// - bank rules only with clock enable high twice
// - read auto precharge: access then precharge period
// - write auto precharge precharges after write recovery
// - auto precharge allows other banks, no data clash
// - wait after write auto precharge to other bank; not checked here, a read to another bank is taken at once
// - wait after read auto precharge to other bank
// - refresh and mode load only all banks idle
// - sample clock enable each edge, use pair
// - low-low holds sleep; rise with nop exits
// - falling clock enable picks the sleep state
// - only nop or deselect during exit period
// - full initialization after deepest sleep exit
// - clock toggles twice during self refresh exit
// - active after activate delay, idle after precharge
// - burst terminate with falling enable: deepest sleep
module sbcl_dram (
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	sbcl_if.dram bus,
	output sbcl_pkg::sbcl_bank_st_t [`SBCL_NBANK-1:0] bank_state,
	output sbcl_pkg::sbcl_pwr_t power_state,
	output logic illegal_cmd,
	output logic init_required
);
	sbcl_pkg::sbcl_dram_s_t r, n;
	sbcl_pkg::sbcl_cmd_t cmd;
	logic [`SBCL_NBANK-1:0] hit;
	logic [`SBCL_NBANK-1:0] rej;
	logic [`SBCL_NBANK-1:0] idle_v;
	logic [`SBCL_NBANK-1:0] rd_v;
	logic ok;
	logic quiet;
	logic all_idle;
	logic any_rd;
	logic cold;

	// deselect ignores the other lines; nop keeps whatever is running
	assign cmd = sbcl_pkg::sbcl_decode(bus.cs_n, {bus.ras_n, bus.cas_n, bus.we_n});
	assign quiet = (cmd == sbcl_pkg::CMD_DESEL) || (cmd == sbcl_pkg::CMD_NOP);
	// bank commands only count with enable high on both edges and no refresh or mode load busy
	assign ok = r.cke_prev && bus.cke && (r.pwr == sbcl_pkg::PW_NORMAL)
		&& (r.busy_tmr == 8'h00) && !cold;
	// after the deepest sleep the array is gone: until a mode load is seen again only
	// precharge, refresh and mode loads are taken, row and column commands are refused
	assign cold = r.init_req && (cmd inside {sbcl_pkg::CMD_ACT, sbcl_pkg::CMD_READ,
		sbcl_pkg::CMD_WRITE, sbcl_pkg::CMD_BST});
	// registered bank states: a refresh on the very edge a precharge ends is flagged,
	// one cycle stricter than the bank trackers; the controller keeps wider margins
	assign all_idle = &idle_v;
	assign any_rd = |rd_v;
	// outputs come straight from the state register
	assign power_state = r.pwr;
	assign illegal_cmd = r.illegal;
	assign init_required = r.init_req;

	// one tracker per bank; each judges only commands addressed to it
	generate
		for (genvar i = 0; i < `SBCL_NBANK; i++) begin : g_bank
			// burst terminate goes to the bank of the latest read, whatever ba says
			// precharge with ap set reaches every bank at once
			assign hit[i] = (cmd == sbcl_pkg::CMD_BST) ? (r.rd_bank == 2'(i))
				: ((bus.ba == 2'(i)) || ((cmd == sbcl_pkg::CMD_PRE) && bus.ap));
			assign idle_v[i] = (bank_state[i] == sbcl_pkg::BK_IDLE);
			assign rd_v[i] = (bank_state[i] == sbcl_pkg::BK_READ)
				|| (bank_state[i] == sbcl_pkg::BK_READ_AP);
			sbcl_bank u_bank (
				.clk(clk),
				.rst(rst),
				.clk_en(clk_en),
				.ok(ok && !(cmd == sbcl_pkg::CMD_WRITE && any_rd)),
				.hit(hit[i]),
				.ap(bus.ap),
				.cmd(cmd),
				.st(bank_state[i]),
				.reject(rej[i])
			);
		end
	endgenerate

	// power state machine driven by the previous and current clock enable samples
	// flow: normal, enable falls into a sleep state, enable rises into the exit period;
	// the deepest sleep skips the exit period and comes back with init_required set,
	// since its array contents are gone and initialization stands in for the exit time
	always_comb begin
		n = r;
		n.illegal = 1'h0;
		n.cke_prev = bus.cke;
		// refresh and mode loads block every command for their own time
		if (r.busy_tmr != 8'h00) begin
			n.busy_tmr = r.busy_tmr - 8'h01;
		end
		case (r.pwr)
			sbcl_pkg::PW_NORMAL: begin
				if (!r.cke_prev) begin
					// reached when enable fell but no sleep state was entered
					n.illegal = !quiet;
				end else if (bus.cke) begin
					if (r.busy_tmr != 8'h00) begin
						n.illegal = !quiet;
					end else begin
						// bank trackers judged this command already; fold in their refusals
						n.illegal = |rej;
						if (cold) begin
							// row and column commands before the mode loads are redone
							n.illegal = 1'h1;
						end
						case (cmd)
							sbcl_pkg::CMD_AREF: begin
								if (!all_idle) begin
									n.illegal = 1'h1;
								end else begin
									n.busy_tmr = 8'(`SBCL_RFC_CYC);
								end
							end
							sbcl_pkg::CMD_LMR: begin
								if (!all_idle) begin
									n.illegal = 1'h1;
								end else begin
									n.busy_tmr = 8'(`SBCL_MRD_CYC);
									n.init_req = 1'h0;
								end
							end
							sbcl_pkg::CMD_WRITE: begin
								// a write may not cut into a read burst of any bank
								if (any_rd) begin
									n.illegal = 1'h1;
								end
							end
							sbcl_pkg::CMD_READ: begin
								if (!rej[bus.ba] && !cold) begin
									n.rd_bank = bus.ba;
								end
							end
							default: n.rd_bank = r.rd_bank;
						endcase
					end
				end else begin
					// high-to-low: the command chooses the sleep state
					if (r.busy_tmr != 8'h00) begin
						n.illegal = 1'h1;
					end else if (quiet) begin
						n.pwr = all_idle ? sbcl_pkg::PW_PRE_PD : sbcl_pkg::PW_ACT_PD;
					end else if (cmd == sbcl_pkg::CMD_BST && all_idle) begin
						// array contents are lost here
						n.pwr = sbcl_pkg::PW_DEEPEST_SLEEP_STATE;
					end else if (cmd == sbcl_pkg::CMD_AREF && all_idle) begin
						n.pwr = sbcl_pkg::PW_SELF_REF;
					end else begin
						n.illegal = 1'h1;
					end
				end
			end
			sbcl_pkg::PW_ACT_PD, sbcl_pkg::PW_PRE_PD, sbcl_pkg::PW_SELF_REF,
			sbcl_pkg::PW_DEEPEST_SLEEP_STATE: begin
				// low-low: hold the state, the command is ignored
				if (bus.cke) begin
					if (!quiet) begin
						n.illegal = 1'h1;
					end else if (r.pwr == sbcl_pkg::PW_DEEPEST_SLEEP_STATE) begin
						n.pwr = sbcl_pkg::PW_NORMAL;
						n.init_req = 1'h1;
					end else begin
						n.pwr = sbcl_pkg::PW_EXIT;
						if (r.pwr == sbcl_pkg::PW_SELF_REF) begin
							n.exit_tmr = 8'(`SBCL_XSR_CYC);
						end else begin
							n.exit_tmr = 8'(`SBCL_XP_CYC);
						end
					end
				end
			end
			sbcl_pkg::PW_EXIT: begin
				// exit period: nothing but nop or deselect, enable stays high
				n.exit_tmr = r.exit_tmr - 8'h01;
				n.illegal = !quiet || !bus.cke;
				// the last counted edge already returns to normal; a command may follow it
				if (r.exit_tmr == 8'h01) begin
					n.pwr = sbcl_pkg::PW_NORMAL;
				end
			end
			// a state outside the one-hot set falls back to normal
			default: n.pwr = sbcl_pkg::PW_NORMAL;
		endcase
	end

	// state register; enable assumed high before reset release
	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '{cke_prev: 1'h1, pwr: sbcl_pkg::PW_NORMAL, default: '0};
		end else if (clk_en) begin
			r <= n;
		end
	end
endmodule : sbcl_dram

// >>> sbcl_if.sv
// Purpose: command bus and clock enable between controller and memory
// Assumes: both ends on the same clk
// Notes: all signals driven by the controller end
`timescale 1ns/10ps
interface sbcl_if;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic cke;
	logic ap;
	logic [1:0] ba;
	modport dram (input cs_n, input ras_n, input cas_n, input we_n, input cke, input ap, input ba);
	modport ctrl (output cs_n, output ras_n, output cas_n, output we_n, output cke, output ap,
		output ba);
endinterface : sbcl_if

// >>> sbcl_pkg.sv
// Purpose: types and command coding shared by both ends
// Assumes: sbcl_consts.svh on the include path
// Notes: state enums are one-hot
`include "sbcl_consts.svh"
package sbcl_pkg;
	typedef enum logic [3:0] {
		CMD_DESEL = 4'h0, CMD_NOP = 4'h1, CMD_ACT = 4'h2, CMD_READ = 4'h3, CMD_WRITE = 4'h4,
		CMD_PRE = 4'h5, CMD_BST = 4'h6, CMD_AREF = 4'h7, CMD_LMR = 4'h8
	} sbcl_cmd_t;
	typedef enum logic [7:0] {
		BK_IDLE = 8'h01, BK_ACTIVATING = 8'h02, BK_ACTIVE = 8'h04, BK_READ = 8'h08,
		BK_WRITE = 8'h10, BK_READ_AP = 8'h20, BK_WRITE_AP = 8'h40, BK_PRECHARGING = 8'h80
	} sbcl_bank_st_t;
	typedef enum logic [5:0] {
		PW_NORMAL = 6'h01, PW_ACT_PD = 6'h02, PW_PRE_PD = 6'h04, PW_SELF_REF = 6'h08,
		PW_DEEPEST_SLEEP_STATE = 6'h10, PW_EXIT = 6'h20
	} sbcl_pwr_t;
	typedef enum logic [3:0] {
		OP_ACT = 4'h0, OP_READ = 4'h1, OP_WRITE = 4'h2, OP_PRE = 4'h3, OP_BST = 4'h4,
		OP_AREF = 4'h5, OP_LMR = 4'h6, OP_PD = 4'h7, OP_SREF = 4'h8, OP_DEEP = 4'h9,
		OP_WAKE = 4'ha
	} sbcl_op_t;
	typedef enum logic [3:0] {
		HS_RUN = 4'h1, HS_SLEEP = 4'h2, HS_EXIT = 4'h4, HS_INIT = 4'h8
	} sbcl_hst_t;
	typedef struct packed {
		sbcl_bank_st_t st;
		logic [`SBCL_TW-1:0] tmr;
	} sbcl_bank_s_t;
	typedef struct packed {
		logic cke_prev;
		sbcl_pwr_t pwr;
		logic [`SBCL_TW-1:0] exit_tmr;
		logic [`SBCL_TW-1:0] busy_tmr;
		logic [1:0] rd_bank;
		logic illegal;
		logic init_req;
	} sbcl_dram_s_t;
	typedef struct packed {
		logic cs_n, ras_n, cas_n, we_n, cke, ap;
		logic [1:0] ba;
		logic hold, hap, ready, last_wr, deep, init_req;
		sbcl_op_t op;
		logic [1:0] bank, lmr_cnt;
		sbcl_hst_t st;
		logic [`SBCL_TW-1:0] since_col, since_any, exit_cnt;
		logic [`SBCL_NBANK-1:0] open;
		logic [15:0] wait_cnt;
	} sbcl_ctrl_s_t;
	// {ras_n, cas_n, we_n} per command, cs_n low
	function automatic sbcl_cmd_t sbcl_decode(input logic cs_n, input logic [2:0] rcw);
		if (cs_n) begin
			return CMD_DESEL;
		end
		case (rcw)
			3'h7: return CMD_NOP;
			3'h3: return CMD_ACT;
			3'h5: return CMD_READ;
			3'h4: return CMD_WRITE;
			3'h2: return CMD_PRE;
			3'h6: return CMD_BST;
			3'h1: return CMD_AREF;
			default: return CMD_LMR;
		endcase
	endfunction : sbcl_decode
	function automatic logic [2:0] sbcl_encode(input sbcl_cmd_t c);
		case (c)
			CMD_ACT: return 3'h3;
			CMD_READ: return 3'h5;
			CMD_WRITE: return 3'h4;
			CMD_PRE: return 3'h2;
			CMD_BST: return 3'h6;
			CMD_AREF: return 3'h1;
			CMD_LMR: return 3'h0;
			default: return 3'h7;
		endcase
	endfunction : sbcl_encode
endpackage : sbcl_pkg

// >>> sbcl_sva.sv
// Purpose: wire checks on the command bus between the two ends
// Assumes: one clock, synchronous reset
// Notes: sees only the interface signals
`timescale 1ns/10ps
module sbcl_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic cke,
	input wire logic ap,
	input wire logic [1:0] ba
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// decoded strobes; deselect counts as a no-operation
	logic [2:0] rcw;
	logic nop, rd, wr;
	assign rcw = {ras_n, cas_n, we_n};
	assign nop = cs_n || rcw == 3'h7;
	assign rd = !cs_n && rcw == 3'h5;
	assign wr = !cs_n && rcw == 3'h4;
	// a falling enable carries only a sleep-entry command
	property p_fall_cmd;
		$fell(cke) |-> nop || rcw == 3'h6 || rcw == 3'h1;
	endproperty
	a_fall_cmd: assert property (p_fall_cmd) else $error("bad command on enable fall");
	property p_rise_nop;
		$rose(cke) |-> nop;
	endproperty
	a_rise_nop: assert property (p_rise_nop) else $error("command on enable rise");
	// the bus must stay quiet for 6 cycles after enable rises, one short of the shortest exit time
	property p_exit_quiet;
		$rose(cke) |=> nop [*6];
	endproperty
	a_exit_quiet: assert property (p_exit_quiet) else $error("command in exit period");
	property p_sleep_hold;
		!cke && !$past(cke) |-> nop;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("command while asleep");
	property p_cmd_pulse;
		!nop |=> nop;
	endproperty
	a_cmd_pulse: assert property (p_cmd_pulse) else $error("command held two cycles");
	property p_rd_wr;
		rd |=> !wr [*4];
	endproperty
	a_rd_wr: assert property (p_rd_wr) else $error("write too soon after read");
	property p_wr_rd;
		wr |=> !rd [*4];
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("read too soon after write");
	property p_rd_rd;
		rd && ap |=> !rd;
	endproperty
	a_rd_rd: assert property (p_rd_rd) else $error("read too soon after read");
	c_read: cover property (rd);
	c_sleep: cover property ($fell(cke));
	c_wake: cover property ($rose(cke) && ba == 2'h0);
endmodule : sbcl_sva

// >>> tb.sv
// Purpose: self-checking bench joining controller and memory ends
// Assumes: init wait cut to 10 cycles
// Notes: banks and read auto precharge drawn at random
`timescale 1ns/10ps
module tb;
	logic clk, rst, clk_en, req_valid, req_ap, req_ready, c_init, asleep, illegal_cmd, d_init;
	logic rap;
	logic [1:0] req_bank, a, b;
	sbcl_pkg::sbcl_op_t req_op;
	sbcl_pkg::sbcl_bank_st_t [3:0] bank_state;
	sbcl_pkg::sbcl_pwr_t power_state;
	int err_total, n_compared, n_ill;
	sbcl_if bus ();
	sbcl_ctrl #(.INIT_WAIT_CYC(10)) i_sbcl_ctrl (.clk(clk), .rst(rst), .clk_en(clk_en),
		.bus(bus), .req_valid(req_valid), .req_op(req_op), .req_bank(req_bank), .req_ap(req_ap),
		.req_ready(req_ready), .init_required(c_init), .asleep(asleep));
	sbcl_dram i_sbcl_dram (.clk(clk), .rst(rst), .clk_en(clk_en), .bus(bus),
		.bank_state(bank_state), .power_state(power_state), .illegal_cmd(illegal_cmd),
		.init_required(d_init));
	sbcl_sva i_sbcl_sva (.clk(clk), .rst(rst), .cs_n(bus.cs_n), .ras_n(bus.ras_n),
		.cas_n(bus.cas_n), .we_n(bus.we_n), .cke(bus.cke), .ap(bus.ap), .ba(bus.ba));
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	// one-cycle reports are counted on the edge where they stand
	always @(posedge clk) begin
		if (illegal_cmd === 1'h1) n_ill <= n_ill + 1;
	end
	task automatic conclude();
		$display("compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	task automatic check(input logic ok, input string what);
		n_compared++;
		if (ok !== 1'h1) begin
			err_total++;
			$display("ERROR at %0t: %s", $time, what);
		end
	endtask : check
	// ready is looked at mid-cycle, so it is settled before the taking edge
	task automatic wait_ready();
		int n;
		n = 0;
		while (req_ready !== 1'h1) begin
			@(negedge clk);
			n++;
			if (n > 200) begin
				check(1'h0, "request hangs");
				conclude();
			end
		end
	endtask : wait_ready
	task automatic issue(input sbcl_pkg::sbcl_op_t op, input logic [1:0] bk, input logic ap,
		input int gap);
		req_op = op;
		req_bank = bk;
		req_ap = ap;
		req_valid = 1'h1;
		wait_ready();
		@(negedge clk);
		req_valid = 1'h0;
		wait_ready();
		repeat (gap) @(negedge clk);
	endtask : issue
	// expected power state for each sleep request of the table
	function automatic sbcl_pkg::sbcl_pwr_t exp_sleep(input int k);
		case (k)
			0: return sbcl_pkg::PW_ACT_PD;
			1: return sbcl_pkg::PW_PRE_PD;
			2: return sbcl_pkg::PW_SELF_REF;
			default: return sbcl_pkg::PW_DEEPEST_SLEEP_STATE;
		endcase
	endfunction : exp_sleep
	function automatic sbcl_pkg::sbcl_op_t sleep_op(input int k);
		return k < 2 ? sbcl_pkg::OP_PD : (k == 2 ? sbcl_pkg::OP_SREF : sbcl_pkg::OP_DEEP);
	endfunction : sleep_op
	initial begin
		rst = 1'h1;
		clk_en = 1'h1;
		req_valid = 1'h0;
		req_op = sbcl_pkg::OP_ACT;
		req_bank = 2'h0;
		req_ap = 1'h0;
		err_total = 0;
		n_compared = 0;
		n_ill = 0;
		void'($urandom(45362));
		repeat (2) @(negedge clk);
		rst = 1'h0;
		// two open rows, then auto precharge traffic across them
		for (int i = 0; i < 6; i++) begin
			a = 2'($urandom);
			b = a + 2'($urandom_range(1, 3));
			rap = 1'($urandom);
			issue(sbcl_pkg::OP_ACT, a, 1'h0, 0);
			issue(sbcl_pkg::OP_ACT, b, 1'h0, 8);
			check(bank_state[a] === sbcl_pkg::BK_ACTIVE, "row a not open");
			check(bank_state[b] === sbcl_pkg::BK_ACTIVE, "row b not open");
			issue(sbcl_pkg::OP_WRITE, a, 1'h1, 0);
			issue(sbcl_pkg::OP_READ, b, rap, 14);
			check(bank_state[a] === sbcl_pkg::BK_IDLE, "write precharge missing");
			check(bank_state[b] === (rap ? sbcl_pkg::BK_IDLE : sbcl_pkg::BK_ACTIVE), "read end");
			issue(sbcl_pkg::OP_PRE, b, 1'h1, 8);
			for (int k = 0; k < 4; k++) check(bank_state[k] === sbcl_pkg::BK_IDLE, "not idle");
		end
		check(n_ill === 0, "legal traffic flagged");
		// a read inside the activate delay must be refused and reported
		issue(sbcl_pkg::OP_ACT, a, 1'h0, 0);
		issue(sbcl_pkg::OP_READ, a, 1'h0, 8);
		check(n_ill === 1, "early read not flagged");
		check(bank_state[a] === sbcl_pkg::BK_ACTIVE, "refused read changed bank");
		// each sleep entry, then wake
		for (int k = 0; k < 4; k++) begin
			issue(sleep_op(k), a, 1'h0, 4);
			check(power_state === exp_sleep(k) && asleep === 1'h1, "sleep state");
			issue(sbcl_pkg::OP_WAKE, a, 1'h0, 40);
			check(power_state === sbcl_pkg::PW_NORMAL && asleep === 1'h0, "no wake");
			if (k == 0) issue(sbcl_pkg::OP_PRE, a, 1'h1, 8);
		end
		check(d_init === 1'h1 && c_init === 1'h1, "no init after deep wake");
		issue(sbcl_pkg::OP_ACT, b, 1'h0, 4);
		check(bank_state[b] === sbcl_pkg::BK_IDLE, "row opened before init");
		issue(sbcl_pkg::OP_PRE, a, 1'h1, 8);
		issue(sbcl_pkg::OP_AREF, a, 1'h0, 22);
		issue(sbcl_pkg::OP_AREF, a, 1'h0, 22);
		issue(sbcl_pkg::OP_LMR, 2'h0, 1'h0, 5);
		issue(sbcl_pkg::OP_LMR, 2'h1, 1'h0, 5);
		check(d_init === 1'h0 && c_init === 1'h0, "init not done");
		check(n_ill === 1, "legal sequence flagged");
		conclude();
	end
endmodule : tb
